// ==== src/ccr_consts.svh ====
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
// ==========================================
// Register offsets
`define CCR_ADDR_THRESH_HIGH 5'h07
`define CCR_ADDR_THRESH_LOW 5'h08
`define CCR_ADDR_CH0_CONFIG 5'h09
`define CCR_ADDR_OCAL_HIGH 5'h0a
`define CCR_ADDR_OCAL_LOW 5'h0b
// ==========================================
// Field positions
`define CCR_TH_LO_MSB 15
`define CCR_TH_LO_LSB 8
`define CCR_COEF_MSB 3
`define CCR_COEF_LSB 0
`define CCR_PHASE_MSB 15
`define CCR_PHASE_LSB 6
`define CCR_BYPASS_BIT 2
`define CCR_MUX_MSB 1
`define CCR_MUX_LSB 0
`define CCR_OCAL_LO_MSB 15
`define CCR_OCAL_LO_LSB 8
// ==========================================
// Reset value and write masks
`define CCR_RESET_WORD 16'h0000
`define CCR_WRITE_MASK_THRESH_LOW 16'hff0f
`define CCR_WRITE_MASK_CH0_CONFIG 16'hffc7
`define CCR_WRITE_MASK_OCAL_LOW 16'hff00
`endif

// ==== src/ccr_pkg.sv ====
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_IN_EXTERNAL = 2'h0,
    CCR_IN_SHORTED = 2'h1,
    CCR_IN_TEST_POS = 2'h2,
    CCR_IN_TEST_NEG = 2'h3
  } ccr_input_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ccr_bus_req_t;

  typedef struct packed {
    logic dc_enable;
    logic [3:0] coef_shift;
    logic signed [9:0] phase_delay;
    ccr_input_t input_sel;
    logic shorted;
    logic test_pos;
    logic test_neg;
  } ccr_ch0_ctrl_t;
endpackage

// ==== src/ccr_reg16.sv ====
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_reg16 #(
  parameter logic [15:0] WMASK = 16'hffff
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);
  // Masked bits never store, so reserved bits stay zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= `CCR_RESET_WORD;
    else if (we)
      q <= wdata & WMASK;
  end
endmodule // ccr_reg16

// ==== src/ccr_dc_decode.sv ====
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_dc_decode
  import ccr_pkg::*;
(
  input wire logic [3:0] coef_code,
  input wire logic bypass,
  output logic dc_enable,
  output logic [3:0] coef_shift
);
  // Shift of 2..15 encodes coefficient 1/2^(code+1); code 15 is undefined and treated as off
  always_comb
  begin
    dc_enable = (coef_code != 4'h0) && (coef_code != 4'hf) && !bypass;
    coef_shift = dc_enable ? 4'(coef_code + 4'h1) : 4'h0;
  end
endmodule // ccr_dc_decode

// ==== src/ccr_top.sv ====
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_top
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic [23:0] current_detect_threshold,
  output logic [3:0] dc_removal_coefficient_select,
  output logic [23:0] channel0_offset_cal,
  output ccr_ch0_ctrl_t ch0_ctrl
);
  // ==========================================
  // Register storage
  logic [15:0] th_high_r;
  logic [15:0] th_low_r;
  logic [15:0] cfg_r;
  logic [15:0] ocal_high_r;
  logic [15:0] ocal_low_r;
  logic dc_en;
  logic [3:0] shift;
  ccr_ch0_ctrl_t ctrl_nxt;

  ccr_reg16 u_th_high (
    .clk(clk), .rstn(rstn), .we(wr && addr == `CCR_ADDR_THRESH_HIGH),
    .wdata(wdata), .q(th_high_r)
  );
  ccr_reg16 #(.WMASK(`CCR_WRITE_MASK_THRESH_LOW)) u_th_low (
    .clk(clk), .rstn(rstn), .we(wr && addr == `CCR_ADDR_THRESH_LOW),
    .wdata(wdata), .q(th_low_r)
  );
  ccr_reg16 #(.WMASK(`CCR_WRITE_MASK_CH0_CONFIG)) u_cfg (
    .clk(clk), .rstn(rstn), .we(wr && addr == `CCR_ADDR_CH0_CONFIG),
    .wdata(wdata), .q(cfg_r)
  );
  ccr_reg16 u_ocal_high (
    .clk(clk), .rstn(rstn), .we(wr && addr == `CCR_ADDR_OCAL_HIGH),
    .wdata(wdata), .q(ocal_high_r)
  );
  ccr_reg16 #(.WMASK(`CCR_WRITE_MASK_OCAL_LOW)) u_ocal_low (
    .clk(clk), .rstn(rstn), .we(wr && addr == `CCR_ADDR_OCAL_LOW),
    .wdata(wdata), .q(ocal_low_r)
  );

  // ==========================================
  // Read port: data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= `CCR_RESET_WORD;
    else if (rd)
    begin
      unique case (addr)
        `CCR_ADDR_THRESH_HIGH: rdata <= th_high_r;
        `CCR_ADDR_THRESH_LOW: rdata <= th_low_r;
        `CCR_ADDR_CH0_CONFIG: rdata <= cfg_r;
        `CCR_ADDR_OCAL_HIGH: rdata <= ocal_high_r;
        `CCR_ADDR_OCAL_LOW: rdata <= ocal_low_r;
        default: rdata <= `CCR_RESET_WORD;
      endcase
    end
    else
      rdata <= `CCR_RESET_WORD;
  end

  // ==========================================
  // Channel 0 control decode
  ccr_dc_decode u_dec (
    .coef_code(th_low_r[`CCR_COEF_MSB:`CCR_COEF_LSB]),
    .bypass(cfg_r[`CCR_BYPASS_BIT]),
    .dc_enable(dc_en),
    .coef_shift(shift)
  );

  always_comb
  begin
    ctrl_nxt.dc_enable = dc_en;
    ctrl_nxt.coef_shift = shift;
    ctrl_nxt.phase_delay = cfg_r[`CCR_PHASE_MSB:`CCR_PHASE_LSB];
    ctrl_nxt.input_sel = ccr_input_t'(cfg_r[`CCR_MUX_MSB:`CCR_MUX_LSB]);
    ctrl_nxt.shorted = (ctrl_nxt.input_sel == CCR_IN_SHORTED);
    ctrl_nxt.test_pos = (ctrl_nxt.input_sel == CCR_IN_TEST_POS);
    ctrl_nxt.test_neg = (ctrl_nxt.input_sel == CCR_IN_TEST_NEG);
  end

  // Outputs are registered so the analog side sees glitch-free controls, one cycle after a write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ch0_ctrl <= '0;
      current_detect_threshold <= 24'h000000;
      dc_removal_coefficient_select <= 4'h0;
      channel0_offset_cal <= 24'h000000;
    end
    else
    begin
      ch0_ctrl <= ctrl_nxt;
      current_detect_threshold <= {th_high_r, th_low_r[`CCR_TH_LO_MSB:`CCR_TH_LO_LSB]};
      dc_removal_coefficient_select <= th_low_r[`CCR_COEF_MSB:`CCR_COEF_LSB];
      channel0_offset_cal <= {ocal_high_r, ocal_low_r[`CCR_OCAL_LO_MSB:`CCR_OCAL_LO_LSB]};
    end
  end
endmodule // ccr_top

// ==== test/ccr_top_checker.sv ====
`timescale 1ns/1ps
// ==========
// Register slice checker
module ccr_top_checker
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [23:0] current_detect_threshold,
  input wire logic [3:0] dc_removal_coefficient_select,
  input wire logic [23:0] channel0_offset_cal,
  input wire ccr_ch0_ctrl_t ch0_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rd_idle_zero_a: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata not idle zero");
  thr_low_a: assert property (wr && addr == 5'h08 |-> ##2 current_detect_threshold[7:0] == $past(wdata[15:8], 2))
    else $error("threshold low byte wrong");
  thr_high_a: assert property (wr && addr == 5'h07 |-> ##2 current_detect_threshold[23:8] == $past(wdata, 2))
    else $error("threshold high wrong");
  dc_off_a: assert property (ch0_ctrl.dc_enable |-> dc_removal_coefficient_select != 4'h0) else $error("dc on at 0");
  coef_shift_a: assert property (ch0_ctrl.dc_enable |-> ch0_ctrl.coef_shift == dc_removal_coefficient_select + 4'h1)
    else $error("coefficient shift wrong");
  phase_a: assert property (wr && addr == 5'h09 |-> ##2 ch0_ctrl.phase_delay == $past(wdata[15:6], 2))
    else $error("phase delay wrong");
  ch_bypass_a: assert property (wr && addr == 5'h09 && wdata[2] |-> ##2 !ch0_ctrl.dc_enable) else $error("bypass ignored");
  mux_decode_a: assert property ({ch0_ctrl.shorted, ch0_ctrl.test_pos, ch0_ctrl.test_neg} ==
    {ch0_ctrl.input_sel == CCR_IN_SHORTED, ch0_ctrl.input_sel == CCR_IN_TEST_POS, ch0_ctrl.input_sel == CCR_IN_TEST_NEG})
    else $error("input decode wrong");
  mux_store_a: assert property (wr && addr == 5'h09 |-> ##2 ch0_ctrl.input_sel == $past(wdata[1:0], 2))
    else $error("input select wrong");
  ocal_high_a: assert property (wr && addr == 5'h0a |-> ##2 channel0_offset_cal[23:8] == $past(wdata, 2))
    else $error("offset high wrong");
  ocal_rsvd_a: assert property (rd && addr == 5'h0b |=> rdata[7:0] == 8'h00) else $error("reserved byte set");
  cover property (wr && addr == 5'h09);
  cover property (rd ##1 rdata != 16'h0000);
  cover property (ch0_ctrl.dc_enable);
endmodule // ccr_top_checker
bind ccr_top ccr_top_checker chk_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .current_detect_threshold(current_detect_threshold),
  .dc_removal_coefficient_select(dc_removal_coefficient_select), .channel0_offset_cal(channel0_offset_cal),
  .ch0_ctrl(ch0_ctrl));

// ==== test/ccr_top_bench.sv ====
`timescale 1ns/1ps
// ==========
// Register slice bench
module ccr_top_bench;
  import ccr_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [23:0] cdt, ocal;
  logic [3:0] coef;
  ccr_ch0_ctrl_t ctl;
  logic [15:0] regv [5] = '{16'hffff, 16'hff0f, 16'hffc7, 16'hffff, 16'hff00};
  int num_errors = 0, cmp_count = 0, cyc = 0;
  ccr_top dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .current_detect_threshold(cdt), .dc_removal_coefficient_select(coef), .channel0_offset_cal(ocal), .ch0_ctrl(ctl));
  initial forever #50 clk = ~clk;
  task chk(input logic [23:0] s, input logic [23:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask
  task wrr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Control outputs trail the register by one edge
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(5'h07 + 5'(i), 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      wrr(5'h07 + 5'(i), 16'hffff);
      rdc(5'h07 + 5'(i), regv[i]);
    end
    wrr(5'h1f, 16'hffff);
    rdc(5'h1f, 16'h0000);
    settle;
    chk(cdt, 24'hffffff);
    chk(ocal, 24'hffffff);
    wrr(5'h09, 16'h0000);
    // Code 15 is undefined and is expected to leave DC removal off
    for (int c = 0; c < 16; c++)
    begin
      wrr(5'h08, 16'(c));
      settle;
      chk(coef, 24'(c));
      chk(ctl.dc_enable, c != 0 && c != 15);
      chk(ctl.coef_shift, (c != 0 && c != 15) ? c + 1 : 0);
    end
    wrr(5'h08, 16'h000e);
    wrr(5'h09, 16'h0004);
    settle;
    chk(ctl.dc_enable, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      wrr(5'h09, 16'h8000 | 16'(m));
      settle;
      chk({ctl.phase_delay, ctl.input_sel, ctl.shorted, ctl.test_pos, ctl.test_neg},
        {10'h200, 2'(m), m == 1, m == 2, m == 3});
      chk(ctl.dc_enable, 1'b1);
    end
    give_verdict;
  end
endmodule // ccr_top_bench
